//--- include/fpdp_consts.svh
`ifndef FPDP_CONSTS_SVH
`define FPDP_CONSTS_SVH
// register byte offsets on the register bus
`define OFF_STATUS  8'h00
`define OFF_FLAGS   8'h04
`define OFF_EXP     8'h08
`define RST_STATUS  16'h0000
// field positions in the flag register
`define FLG_OVF     0
`define FLG_ZERO    1
`define FLG_NEG     2
`define FLG_BNEG    3
`define FLG_BZERO   4
`define FLG_CONV    5
// shift count field in the exponent register
`define EXP_SC_LSB  16
// function codes with fixed meaning
`define EXPONENT_ALU_PASS_A 3'h4
`define FRACTION_ALU_PASS_B 3'h2
// shifter limits
`define SHL_MAX     4'h7
`define SHR_MAX     4'h8
`define ACC_N       8
`define QUAD_TOP    2'h3
`endif

//--- include/fpdp_pkg.sv
package fpdp_pkg;
	typedef enum logic [1:0] {
		DO_STORE  = 2'h0,
		DO_STATUS = 2'h1,
		DO_ADDR   = 2'h2,
		DO_OPND   = 2'h3
	} dout_sel_t;
	typedef enum logic [1:0] {
		DI_EXC  = 2'h0,
		DI_EXPONENT_ALU = 2'h1,
		DI_OPND = 2'h2
	} din_sel_t;
	typedef enum logic [1:0] {
		AS_SC    = 2'h0,
		AS_BANK  = 2'h1,
		AS_ABSSC = 2'h2,
		AS_EXPONENT_RESULT_REG  = 2'h3
	} asel_t;
	typedef enum logic [1:0] {
		BS_CONST = 2'h0,
		BS_SHIFT = 2'h1,
		BS_DIN   = 2'h2,
		BS_BANK  = 2'h3
	} bsel_t;
endpackage

//--- core/exp_bank.sv
// one exponent scratchpad bank: sign plus exponent per accumulator
module exp_bank (
	input  wire logic       clk,
	input  wire logic       we,
	input  wire logic [2:0] wr_addr,
	input  wire logic [8:0] wr_data,
	input  wire logic [2:0] rd_addr,
	output logic      [8:0] rd_data
);
	logic [8:0] mem [0:7];

	// synchronous write, asynchronous read
	always_ff @(posedge clk) begin
		if (we) begin
			mem[wr_addr] <= wr_data;
		end
	end

	assign rd_data = mem[rd_addr];
endmodule

//--- core/frac_shifter.sv
// one-pass fraction shifter, left 0..7 or right 0..8
`include "fpdp_consts.svh"
module frac_shifter (
	input  wire logic        left,
	input  wire logic [3:0]  amt,
	input  wire logic [59:0] din,
	output logic      [59:0] dout
);
	logic [3:0] lim;

	// amounts past the limit are clipped to the limit
	always_comb begin
		lim = amt;
		if (left && amt > `SHL_MAX) begin
			lim = `SHL_MAX;
		end
		if (!left && amt > `SHR_MAX) begin
			lim = `SHR_MAX;
		end
		dout = left ? (din << lim) : (din >> lim);
	end
endmodule

//--- core/float_unit_datapath.sv
// Function
// - data out mux, 16 bits, returns store buffer, status, address or operand
// - data in mux, 16 bits, picks exception address, exponent alu or operand
// - accumulator input mux, 16 bits: alu word or data in word
// - exponent alu write goes into both exponent banks in one cycle
// - first memory word splits sign/exponent and seven fraction bits
// - two banks of nine bits, one entry per accumulator
// - banks read independently so both exponents are seen together
// - writes address both banks alike; fraction follows bank b address
// - overflow flag taken from exponent alu bit 8
// - zero and branch zero when exponent or data in bits 14:7 zero
// - branch negative from exponent alu bit 9 or data in bit 15
// - exponent a select: shift count, bank a, shift count magnitude, result
// - exponent b select: constant, shift bus, data in 6:0, bank b
// - exponent alu is 10 bits with arithmetic and logic functions
// - 10-bit shift count register and 10-bit exponent result register
// - eight 56-bit fraction accumulators
// - accumulator out mux picks a quadrant or the status word
// - fraction alu 60 bits, loads the fraction work register
// - work shifter shifts left 0..7 or right 0..8
// - quotient register loads scratchpad or its own shifted value
// - exponent alu code 4 passes a input
// - fraction alu code 2 passes b input
//
// Decided for this implementation: the register offsets and the APB register port.
`include "fpdp_consts.svh"
module float_unit_datapath
	import fpdp_pkg::*;
(
	input  wire logic        REF_CLK,
	input  wire logic        NRST,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	input  wire logic [15:0] HOST_DATA_IN,
	input  wire logic        OPERAND_LOAD,
	input  wire logic        ADDRESS_LOAD,
	output logic      [15:0] HOST_DATA_OUT,
	input  wire dout_sel_t   DOUT_SEL,
	input  wire din_sel_t    DIN_SEL,
	input  wire logic        EXC_LOAD,
	input  wire logic        STORE_WE,
	input  wire logic        ACC_SEL_DIN,
	input  wire logic        SIGN_IN,
	input  wire logic        SIGN_SET,
	input  wire logic        CONV_ERR,
	input  wire logic        CC_WE,
	input  wire logic [2:0]  ADDR_A,
	input  wire logic [2:0]  ADDR_B,
	input  wire logic        EXP_WE,
	input  wire logic        FRAC_WE,
	input  wire logic [1:0]  ACC_QUAD,
	input  wire logic [1:0]  ACO_QUAD,
	input  wire logic        ACO_STATUS,
	input  wire asel_t       A_SEL,
	input  wire bsel_t       B_SEL,
	input  wire logic [7:0]  EXP_CONST,
	input  wire logic [9:0]  SHIFT_BUS,
	input  wire logic [2:0]  EXPONENT_ALU_FN,
	input  wire logic        SC_WE,
	input  wire logic        EXPONENT_RESULT_REG_WE,
	input  wire logic        FMX_SEL_Q,
	input  wire logic        ROUND,
	input  wire logic [2:0]  FRACTION_ALU_FN,
	input  wire logic        WORK_WE,
	input  wire logic        WSH_LEFT,
	input  wire logic [3:0]  WSH_AMT,
	input  wire logic        QMX_SEL_SHIFT,
	input  wire logic        QUOTIENT_REG_WE,
	input  wire logic        QSH_LEFT,
	input  wire logic [3:0]  QSH_AMT
);
	logic [15:0] operand_q;
	logic [15:0] instr_addr_q;
	logic [15:0] exc_addr_q;
	logic [15:0] store_buf_q;
	logic [15:0] status_q;
	logic [15:0] dout_q;
	logic [31:0] prdata_q;
	logic [15:0] dout_w;
	logic [15:0] din_w;
	logic [15:0] acc_in_w;
	logic [15:0] aco_w;
	logic [15:0] fslice_w;
	logic [8:0]  bank_a_rd;
	logic [8:0]  bank_b_rd;
	logic [2:0]  bank_a_addr;
	logic [9:0]  asel_w;
	logic [9:0]  bsel_w;
	logic [9:0]  abs_sc_w;
	logic [9:0]  exponent_alu_w;
	logic [9:0]  sc_q;
	logic [9:0]  exponent_result_reg_q;
	logic [55:0] frac_acc [0:`ACC_N-1];
	logic [55:0] frac_rd;
	logic [59:0] fmx_w;
	logic [59:0] fraction_alu_w;
	logic [59:0] work_q;
	logic [59:0] wsh_w;
	logic [59:0] quo_q;
	logic [59:0] qsh_w;
	logic        ovf_q;
	logic        zero_q;
	logic        neg_q;
	logic        bneg_q;
	logic        bzero_q;
	logic        conv_q;
	logic        din_zero_w;
	logic        din_neg_w;
	logic        wr_acc;

	// host-facing holding registers
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			operand_q    <= 16'h0000;
			instr_addr_q <= 16'h0000;
			exc_addr_q   <= 16'h0000;
			store_buf_q  <= 16'h0000;
			dout_q       <= 16'h0000;
		end else begin
			if (OPERAND_LOAD) begin
				operand_q <= HOST_DATA_IN;
			end
			if (ADDRESS_LOAD) begin
				instr_addr_q <= HOST_DATA_IN;
			end
			if (EXC_LOAD) begin
				exc_addr_q <= instr_addr_q;
			end
			if (STORE_WE) begin
				store_buf_q <= aco_w;
			end
			dout_q <= dout_w;
		end
	end

	assign HOST_DATA_OUT = dout_q;

	// data out and data in multiplexers
	always_comb begin
		unique case (DOUT_SEL)
			DO_STORE:  dout_w = store_buf_q;
			DO_STATUS: dout_w = status_q;
			DO_ADDR:   dout_w = instr_addr_q;
			DO_OPND:   dout_w = operand_q;
		endcase
		case (DIN_SEL)
			DI_EXC:  din_w = exc_addr_q;
			DI_EXPONENT_ALU: din_w = {6'h00, exponent_alu_w};
			DI_OPND: din_w = operand_q;
			default: din_w = 16'h0000;
		endcase
	end

	// alu word: sign, exponent and seven fraction bits on the top quadrant
	assign fslice_w = fraction_alu_w[{ACC_QUAD, 4'h0} + 6'd3 +: 16];
	assign acc_in_w = ACC_SEL_DIN ? din_w :
		(ACC_QUAD == `QUAD_TOP) ? {SIGN_IN, exponent_alu_w[7:0], fslice_w[6:0]} : fslice_w;

	// writes put both banks on bank b's address
	assign wr_acc      = EXP_WE | FRAC_WE;
	assign bank_a_addr = wr_acc ? ADDR_B : ADDR_A;

	// one write strobe and one data word feed both banks
	exp_bank u_bank_a (
		.clk     (REF_CLK),
		.we      (EXP_WE),
		.wr_addr (ADDR_B),
		.wr_data (acc_in_w[15:7]),
		.rd_addr (bank_a_addr),
		.rd_data (bank_a_rd)
	);
	exp_bank u_bank_b (
		.clk     (REF_CLK),
		.we      (EXP_WE),
		.wr_addr (ADDR_B),
		.wr_data (acc_in_w[15:7]),
		.rd_addr (ADDR_B),
		.rd_data (bank_b_rd)
	);

	// fraction scratchpads, written a quadrant at a time
	always_ff @(posedge REF_CLK) begin
		if (FRAC_WE) begin
			if (ACC_QUAD == `QUAD_TOP) begin
				frac_acc[ADDR_B][55:48] <= {1'b0, acc_in_w[6:0]};
			end else begin
				frac_acc[ADDR_B][{ACC_QUAD, 4'h0} +: 16] <= acc_in_w;
			end
		end
	end

	assign frac_rd = frac_acc[ADDR_B];

	// accumulator out mux with status select
	always_comb begin
		if (ACO_STATUS) begin
			aco_w = status_q;
		end else if (ACO_QUAD == `QUAD_TOP) begin
			aco_w = {bank_b_rd, frac_rd[54:48]};
		end else begin
			aco_w = frac_rd[{ACO_QUAD, 4'h0} +: 16];
		end
	end

	// exponent select multiplexers
	assign abs_sc_w = sc_q[9] ? 10'(-sc_q) : sc_q;
	always_comb begin
		unique case (A_SEL)
			AS_SC:    asel_w = sc_q;
			AS_BANK:  asel_w = {1'b0, bank_a_rd};
			AS_ABSSC: asel_w = abs_sc_w;
			AS_EXPONENT_RESULT_REG:  asel_w = exponent_result_reg_q;
		endcase
		unique case (B_SEL)
			BS_CONST: bsel_w = {2'h0, EXP_CONST};
			BS_SHIFT: bsel_w = SHIFT_BUS;
			BS_DIN:   bsel_w = {3'h0, din_w[6:0]};
			BS_BANK:  bsel_w = {1'b0, bank_b_rd};
		endcase
	end

	// exponent alu
	always_comb begin
		unique case (EXPONENT_ALU_FN)
			3'h0:         exponent_alu_w = asel_w + bsel_w;
			3'h1:         exponent_alu_w = asel_w - bsel_w;
			3'h2:         exponent_alu_w = asel_w & bsel_w;
			3'h3:         exponent_alu_w = asel_w | bsel_w;
			`EXPONENT_ALU_PASS_A: exponent_alu_w = asel_w;
			3'h5:         exponent_alu_w = bsel_w;
			3'h6:         exponent_alu_w = asel_w + 10'h001;
			3'h7:         exponent_alu_w = asel_w ^ bsel_w;
		endcase
	end

	// shift count and exponent result registers
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			sc_q   <= 10'h000;
			exponent_result_reg_q <= 10'h000;
		end else begin
			if (SC_WE) begin
				sc_q <= exponent_alu_w;
			end
			if (EXPONENT_RESULT_REG_WE) begin
				exponent_result_reg_q <= exponent_alu_w;
			end
		end
	end

	// condition codes from the exponent alu and the load path
	assign din_zero_w = ACC_SEL_DIN ? (din_w[14:7] == 8'h00) : (exponent_alu_w[7:0] == 8'h00);
	assign din_neg_w  = ACC_SEL_DIN & din_w[15];
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			ovf_q   <= 1'b0;
			zero_q  <= 1'b0;
			neg_q   <= 1'b0;
			bneg_q  <= 1'b0;
			bzero_q <= 1'b0;
			conv_q  <= 1'b0;
		end else if (CC_WE) begin
			ovf_q   <= exponent_alu_w[8];
			zero_q  <= din_zero_w;
			bzero_q <= din_zero_w;
			neg_q   <= SIGN_SET | din_neg_w;
			bneg_q  <= exponent_alu_w[9] | din_neg_w;
			conv_q  <= CONV_ERR;
		end
	end

	// fraction select, with a round bit in the top guard position
	assign fmx_w = FMX_SEL_Q ? qsh_w : ({1'b0, frac_rd, 3'h0} | {57'h0, ROUND, 2'h0});

	// fraction alu
	always_comb begin
		unique case (FRACTION_ALU_FN)
			3'h0:         fraction_alu_w = wsh_w + fmx_w;
			3'h1:         fraction_alu_w = wsh_w - fmx_w;
			`FRACTION_ALU_PASS_B: fraction_alu_w = fmx_w;
			3'h3:         fraction_alu_w = wsh_w;
			3'h4:         fraction_alu_w = wsh_w & fmx_w;
			3'h5:         fraction_alu_w = wsh_w | fmx_w;
			3'h6:         fraction_alu_w = wsh_w ^ fmx_w;
			3'h7:         fraction_alu_w = 60'h0;
		endcase
	end

	frac_shifter u_work_shift (
		.left (WSH_LEFT),
		.amt  (WSH_AMT),
		.din  (work_q),
		.dout (wsh_w)
	);
	frac_shifter u_quo_shift (
		.left (QSH_LEFT),
		.amt  (QSH_AMT),
		.din  (quo_q),
		.dout (qsh_w)
	);

	// fraction work and quotient registers
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			work_q <= 60'h0;
			quo_q  <= 60'h0;
		end else begin
			if (WORK_WE) begin
				work_q <= fraction_alu_w;
			end
			if (QUOTIENT_REG_WE) begin
				quo_q <= QMX_SEL_SHIFT ? qsh_w : {1'b0, frac_rd, 3'h0};
			end
		end
	end

	// register bus slave, no wait states; read data captured in setup
	assign PREADY  = 1'b1;
	assign PRDATA  = prdata_q;
	assign PSLVERR = PSEL & PENABLE & (PWRITE ? (PADDR != `OFF_STATUS) :
		(PADDR != `OFF_STATUS && PADDR != `OFF_FLAGS && PADDR != `OFF_EXP));
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			prdata_q <= 32'h0;
			status_q <= `RST_STATUS;
		end else begin
			if (PSEL && !PENABLE) begin
				prdata_q <= 32'h0;
				if (PADDR == `OFF_STATUS) begin
					prdata_q[15:0] <= status_q;
				end
				if (PADDR == `OFF_FLAGS) begin
					prdata_q[`FLG_OVF]   <= ovf_q;
					prdata_q[`FLG_ZERO]  <= zero_q;
					prdata_q[`FLG_NEG]   <= neg_q;
					prdata_q[`FLG_BNEG]  <= bneg_q;
					prdata_q[`FLG_BZERO] <= bzero_q;
					prdata_q[`FLG_CONV]  <= conv_q;
				end
				if (PADDR == `OFF_EXP) begin
					prdata_q[9:0]                  <= exponent_result_reg_q;
					prdata_q[`EXP_SC_LSB +: 10]    <= sc_q;
				end
			end
			if (PSEL && PENABLE && PWRITE && PADDR == `OFF_STATUS) begin
				status_q <= PWDATA[15:0];
			end
		end
	end

	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!NRST);

	sequence s_top_load;
		FRAC_WE && EXP_WE && ACC_SEL_DIN && ACC_QUAD == `QUAD_TOP;
	endsequence
	sequence s_read_back;
		ADDR_B == $past(ADDR_B) && ACO_QUAD == `QUAD_TOP && !ACO_STATUS && !wr_acc;
	endsequence

	a_dout_status: assert property (DOUT_SEL == DO_STATUS |=> HOST_DATA_OUT == $past(status_q))
		else $error("data out does not show status");
	a_top_split: assert property (s_top_load ##1 s_read_back |-> aco_w == $past(din_w))
		else $error("first word not split into bank and fraction");
	a_bank_dual: assert property ((EXP_WE ##1 (!EXP_WE && ADDR_A == $past(ADDR_B)
		&& ADDR_B == $past(ADDR_B))) |-> bank_a_rd == bank_b_rd)
		else $error("exponent banks differ after a write");
	a_ovf_flag: assert property (CC_WE |=> ovf_q == $past(exponent_alu_w[8]))
		else $error("overflow flag not from exponent bit 8");
	a_zero_load: assert property (CC_WE && ACC_SEL_DIN && din_w[14:7] == 8'h00 |=> zero_q && bzero_q)
		else $error("zero flags not set on zero exponent");
	a_bneg_flag: assert property (CC_WE && exponent_alu_w[9] |=> bneg_q)
		else $error("branch negative not set from exponent bit 9");
	a_exponent_alu_pass: assert property (EXPONENT_ALU_FN == `EXPONENT_ALU_PASS_A && EXPONENT_RESULT_REG_WE |=> exponent_result_reg_q == $past(asel_w))
		else $error("exponent alu code 4 does not pass a");
	a_fraction_alu_pass: assert property (FRACTION_ALU_FN == `FRACTION_ALU_PASS_B && WORK_WE |=> work_q == $past(fmx_w))
		else $error("fraction alu code 2 does not pass b");
	a_shift_left: assert property (WSH_LEFT && WSH_AMT == 4'h1 |-> wsh_w == {work_q[58:0], 1'b0})
		else $error("work shifter left by one is wrong");
	a_quotient_reg_shift: assert property (QUOTIENT_REG_WE && QMX_SEL_SHIFT |=> quo_q == $past(qsh_w))
		else $error("quotient register did not take its shifted value");
endmodule

//--- tb/host_cpu_model.sv
// host side: bus master for the registers and source of operand words
module host_cpu_model (
	input  wire logic        clk,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic      [7:0]  paddr,
	output logic      [31:0] pwdata,
	input  wire logic        pready,
	output logic      [15:0] word,
	output logic             opnd_ld,
	output logic             addr_ld,
	output logic             hang
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		{psel, penable, pwrite, opnd_ld, addr_ld, hang} = '0;
		paddr = '0;
		pwdata = '0;
		word = 16'ha5a5;
	end
	// one transfer, request held until pready is seen high
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 64);
		if (n >= 64) hang <= 1'b1;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// word handed over with a one-cycle strobe; line scrambled afterwards
	task automatic put(input logic [15:0] v, input logic to_addr);
		@(posedge clk);
		word <= v;
		opnd_ld <= !to_addr;
		addr_ld <= to_addr;
		@(posedge clk);
		word <= ~v;
		opnd_ld <= 1'b0;
		addr_ld <= 1'b0;
	endtask
endmodule

//--- tb/float_unit_datapath_bench.sv
`include "fpdp_consts.svh"
module float_unit_datapath_bench;
	import fpdp_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic REF_CLK, NRST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, OPERAND_LOAD, ADDRESS_LOAD;
	logic [7:0] PADDR, EXP_CONST;
	logic [31:0] PWDATA, PRDATA;
	logic [15:0] HOST_DATA_IN, HOST_DATA_OUT, w, v;
	dout_sel_t DOUT_SEL;
	din_sel_t DIN_SEL;
	asel_t A_SEL;
	bsel_t B_SEL;
	logic EXC_LOAD, STORE_WE, ACC_SEL_DIN, SIGN_IN, SIGN_SET, CONV_ERR, CC_WE, EXP_WE, FRAC_WE;
	logic ACO_STATUS, SC_WE, EXPONENT_RESULT_REG_WE, FMX_SEL_Q, ROUND, WORK_WE, WSH_LEFT, QMX_SEL_SHIFT, QUOTIENT_REG_WE, QSH_LEFT;
	logic [2:0] ADDR_A, ADDR_B, EXPONENT_ALU_FN, FRACTION_ALU_FN;
	logic [1:0] ACC_QUAD, ACO_QUAD;
	logic [9:0] SHIFT_BUS;
	logic [3:0] WSH_AMT, QSH_AMT;
	logic hchk, hang;
	logic [32:0] q[$];
	int error_cnt = 0;
	int n_tests = 0;

	float_unit_datapath i_dut (.REF_CLK(REF_CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
		.PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
		.HOST_DATA_IN(HOST_DATA_IN), .OPERAND_LOAD(OPERAND_LOAD), .ADDRESS_LOAD(ADDRESS_LOAD),
		.HOST_DATA_OUT(HOST_DATA_OUT), .DOUT_SEL(DOUT_SEL), .DIN_SEL(DIN_SEL), .EXC_LOAD(EXC_LOAD),
		.STORE_WE(STORE_WE), .ACC_SEL_DIN(ACC_SEL_DIN), .SIGN_IN(SIGN_IN), .SIGN_SET(SIGN_SET),
		.CONV_ERR(CONV_ERR), .CC_WE(CC_WE), .ADDR_A(ADDR_A), .ADDR_B(ADDR_B), .EXP_WE(EXP_WE),
		.FRAC_WE(FRAC_WE), .ACC_QUAD(ACC_QUAD), .ACO_QUAD(ACO_QUAD), .ACO_STATUS(ACO_STATUS),
		.A_SEL(A_SEL), .B_SEL(B_SEL), .EXP_CONST(EXP_CONST), .SHIFT_BUS(SHIFT_BUS), .EXPONENT_ALU_FN(EXPONENT_ALU_FN),
		.SC_WE(SC_WE), .EXPONENT_RESULT_REG_WE(EXPONENT_RESULT_REG_WE), .FMX_SEL_Q(FMX_SEL_Q), .ROUND(ROUND), .FRACTION_ALU_FN(FRACTION_ALU_FN),
		.WORK_WE(WORK_WE), .WSH_LEFT(WSH_LEFT), .WSH_AMT(WSH_AMT), .QMX_SEL_SHIFT(QMX_SEL_SHIFT),
		.QUOTIENT_REG_WE(QUOTIENT_REG_WE), .QSH_LEFT(QSH_LEFT), .QSH_AMT(QSH_AMT));
	host_cpu_model i_host (.clk(REF_CLK), .psel(PSEL), .penable(PENABLE), .pwrite(PWRITE), .paddr(PADDR),
		.pwdata(PWDATA), .pready(PREADY), .word(HOST_DATA_IN), .opnd_ld(OPERAND_LOAD),
		.addr_ld(ADDRESS_LOAD), .hang(hang));

	initial begin
		REF_CLK = 1'b0;
		forever #20 REF_CLK = ~REF_CLK;
	end

	task automatic end_of_test;
		error_cnt = error_cnt + q.size() + int'(hang);
		$display("checks %0d, mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// oldest note against the result just seen
	task automatic cmp(input logic [32:0] got);
		logic [32:0] e;
		n_tests++;
		e = (q.size() > 0) ? q.pop_front() : 33'h1_dead_beef;
		if (got !== e) begin
			error_cnt++;
			$display("CHECK FAILED port word expected %h seen %h", e, got);
		end
	endtask
	// watcher: bus completions and host output samples
	always @(posedge REF_CLK) begin
		if ((PSEL && PENABLE && PREADY) === 1'b1) cmp({PSLVERR, PWRITE ? 32'h0 : PRDATA});
		if (hchk) cmp({17'h0, HOST_DATA_OUT});
	end
	task automatic rd(input logic [7:0] a, input logic [32:0] e);
		q.push_back(e);
		i_host.xfer(1'b0, a, 32'h0);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
		q.push_back({e, 32'h0});
		i_host.xfer(1'b1, a, d);
	endtask
	task automatic hout(input dout_sel_t s, input logic [15:0] e);
		@(posedge REF_CLK);
		DOUT_SEL <= s;
		@(posedge REF_CLK);
		q.push_back({17'h0, e});
		hchk <= 1'b1;
		@(posedge REF_CLK);
		hchk <= 1'b0;
	endtask
	// one exponent alu step with chosen enables
	task automatic eop(input asel_t a, input bsel_t b, input logic [2:0] fn, input logic [7:0] k,
		input logic sc, input logic er, input logic cc);
		@(posedge REF_CLK);
		A_SEL <= a;
		B_SEL <= b;
		{EXPONENT_ALU_FN, EXP_CONST} <= {fn, k};
		{SC_WE, EXPONENT_RESULT_REG_WE, CC_WE} <= {sc, er, cc};
		@(posedge REF_CLK);
		{SC_WE, EXPONENT_RESULT_REG_WE, CC_WE} <= 3'h0;
	endtask

	initial begin
		repeat (5000) @(posedge REF_CLK);
		error_cnt++;
		end_of_test();
	end

	initial begin
		{NRST, hchk, EXC_LOAD, STORE_WE, ACC_SEL_DIN, SIGN_IN, SIGN_SET, CONV_ERR, CC_WE} = '0;
		{EXP_WE, FRAC_WE, ACO_STATUS, SC_WE, EXPONENT_RESULT_REG_WE, FMX_SEL_Q, ROUND, WORK_WE, WSH_LEFT} = '0;
		{QMX_SEL_SHIFT, QUOTIENT_REG_WE, QSH_LEFT, ADDR_A, ADDR_B, EXPONENT_ALU_FN, FRACTION_ALU_FN, ACC_QUAD, ACO_QUAD} = '0;
		{EXP_CONST, SHIFT_BUS, WSH_AMT, QSH_AMT} = '0;
		DOUT_SEL = DO_STORE;
		DIN_SEL = DI_EXC;
		A_SEL = AS_SC;
		B_SEL = BS_CONST;
		void'($urandom(63));
		w = 16'($urandom);
		v = 16'($urandom);
		repeat (5) @(posedge REF_CLK);
		NRST <= 1'b1;
		rd(`OFF_STATUS, 33'h0);
		wr(`OFF_STATUS, {16'h0, w}, 1'b0);
		rd(`OFF_STATUS, {17'h0, w});
		hout(DO_STATUS, w);
		wr(`OFF_FLAGS, 32'h3f, 1'b1);
		rd(8'h0c, {1'b1, 32'h0});
		i_host.put(v, 1'b1);
		hout(DO_ADDR, v);
		// exponent path: count 0ff, then a+b overflows into bit 8
		eop(AS_SC, BS_CONST, 3'h5, 8'hff, 1'b1, 1'b0, 1'b0);
		SIGN_SET <= 1'b1;
		eop(AS_SC, BS_CONST, 3'h0, 8'hff, 1'b0, 1'b1, 1'b1);
		SIGN_SET <= 1'b0;
		rd(`OFF_FLAGS, 33'h05);
		rd(`OFF_EXP, 33'h0_00ff_01fe);
		// load path: negative word with zero exponent field
		i_host.put({1'b1, 8'h00, v[6:0]}, 1'b0);
		{ACC_SEL_DIN, CONV_ERR} <= 2'h3;
		DIN_SEL <= DI_OPND;
		eop(AS_SC, BS_CONST, 3'h5, 8'h01, 1'b0, 1'b0, 1'b1);
		rd(`OFF_FLAGS, 33'h3e);
		{ACC_SEL_DIN, CONV_ERR} <= 2'h0;
		eop(AS_SC, BS_CONST, 3'h5, 8'h00, 1'b0, 1'b0, 1'b1);
		rd(`OFF_FLAGS, 33'h12);
		eop(AS_SC, BS_DIN, 3'h5, 8'h00, 1'b0, 1'b1, 1'b0);
		rd(`OFF_EXP, {17'h000ff, 6'h00, 3'h0, v[6:0]});
		// first memory word into accumulator 6, top quadrant
		i_host.put(w, 1'b0);
		hout(DO_OPND, w);
		@(posedge REF_CLK);
		{ADDR_B, ACC_QUAD, ACC_SEL_DIN, EXP_WE, FRAC_WE} <= {3'h6, 2'h3, 1'b1, 1'b1, 1'b1};
		@(posedge REF_CLK);
		{EXP_WE, FRAC_WE, ACC_SEL_DIN, ACO_QUAD, STORE_WE} <= {1'b0, 1'b0, 1'b0, `QUAD_TOP, 1'b1};
		A_SEL <= AS_BANK;
		{ADDR_A, EXPONENT_ALU_FN, EXPONENT_RESULT_REG_WE} <= {3'h6, `EXPONENT_ALU_PASS_A, 1'b1};
		repeat (2) @(posedge REF_CLK);
		{STORE_WE, EXPONENT_RESULT_REG_WE} <= 2'h0;
		hout(DO_STORE, w);
		rd(`OFF_EXP, {17'h000ff, 7'h00, w[15:7]});
		// remaining quadrants of accumulator 6 from the operand word
		@(posedge REF_CLK);
		{ACC_SEL_DIN, FRAC_WE, ACC_QUAD} <= {1'b1, 1'b1, 2'h2};
		@(posedge REF_CLK);
		ACC_QUAD <= 2'h1;
		@(posedge REF_CLK);
		ACC_QUAD <= 2'h0;
		@(posedge REF_CLK);
		// fraction through the b pass into work and quotient registers
		{ACC_SEL_DIN, FRAC_WE, FMX_SEL_Q, ROUND} <= 4'h0;
		{FRACTION_ALU_FN, WORK_WE, QUOTIENT_REG_WE, QMX_SEL_SHIFT} <= {`FRACTION_ALU_PASS_B, 1'b1, 1'b1, 1'b0};
		@(posedge REF_CLK);
		// work shifted left once, low slice written to accumulator 5
		{FRACTION_ALU_FN, WORK_WE, QMX_SEL_SHIFT, WSH_LEFT, WSH_AMT} <= {3'h3, 1'b0, 1'b1, 1'b1, 4'h1};
		{FRAC_WE, ADDR_B} <= {1'b1, 3'h5};
		@(posedge REF_CLK);
		{FRAC_WE, QUOTIENT_REG_WE, ACO_QUAD, STORE_WE} <= {1'b0, 1'b0, 2'h0, 1'b1};
		@(posedge REF_CLK);
		STORE_WE <= 1'b0;
		hout(DO_STORE, {w[14:0], 1'b0});
		repeat (2) @(posedge REF_CLK);
		end_of_test();
	end
endmodule
